// [logic/aem_params.svh]
// Register offsets, reset values and protocol constants of the entry matcher.
`ifndef AEM_PARAMS_SVH
`define AEM_PARAMS_SVH
`define AEM_OFF_CTRL 12'h000
`define AEM_OFF_ARP 12'h004
`define AEM_OFF_SPA 12'h008
`define AEM_OFF_SPM 12'h00c
`define AEM_OFF_TPA 12'h010
`define AEM_OFF_TPM 12'h014
`define AEM_OFF_IP 12'h018
`define AEM_OFF_STAT 12'h01c
`define AEM_OFF_HITS 12'h020
`define AEM_CTRL_RST 32'h0000_0000
`define AEM_ARP_RST 32'h0000_0000
`define AEM_IP_RST 32'h0000_0000
`define AEM_HLEN_ETH 8'h06
`define AEM_PLEN_IP4 8'h04
`define AEM_HW_ETH 16'h0001
`define AEM_PRO_IP 16'h0800
`define AEM_PROTO_ICMP 8'h01
`define AEM_PROTO_TCP 8'h06
`define AEM_PROTO_UDP 8'h11
`define AEM_OP_ARP_REQ 16'h0001
`define AEM_OP_ARP_REP 16'h0002
`define AEM_OP_RARP_REQ 16'h0003
`define AEM_OP_RARP_REP 16'h0004
`endif

// [logic/aem_pkg.sv]
// Types shared by the entry matcher.
package aem_pkg;
	typedef enum logic [1:0] {AEM_TRI_ANY = 2'h0, AEM_TRI_ZERO = 2'h1, AEM_TRI_ONE = 2'h2} aem_tri_t;
	typedef enum logic [1:0] {AEM_ADR_ANY = 2'h0, AEM_ADR_HOST = 2'h1, AEM_ADR_NET = 2'h2} aem_adr_t;
	typedef enum logic [2:0] {
		AEM_PR_ANY = 3'h0, AEM_PR_SPEC = 3'h1, AEM_PR_ICMP = 3'h2, AEM_PR_UDP = 3'h3,
		AEM_PR_TCP = 3'h4
	} aem_proto_t;
	typedef enum logic [1:0] {AEM_FT_OTHER = 2'h0, AEM_FT_ARP = 2'h1, AEM_FT_IPV4 = 2'h2} aem_ftype_t;
	typedef enum logic [1:0] {AEM_OPK_ANY = 2'h0, AEM_OPK_ARP = 2'h1, AEM_OPK_RARP = 2'h2,
		AEM_OPK_OTHER = 2'h3} aem_opk_t;
	typedef enum logic [1:0] {AEM_RR_ANY = 2'h0, AEM_RR_REQ = 2'h1, AEM_RR_REP = 2'h2} aem_rr_t;
	// Decoded header fields presented by the ingress parser for one frame.
	typedef struct packed {
		aem_ftype_t ftype;
		logic [47:0] frame_source_hw_address;
		logic [15:0] hw_space_code;
		logic [15:0] pro_space;
		logic [7:0] hw_len;
		logic [7:0] pro_len;
		logic [15:0] opcode;
		logic [47:0] sender_hw;
		logic [31:0] sender_protocol_address;
		logic [47:0] target_hw;
		logic [31:0] target_protocol_address;
		logic [7:0] ip_proto;
		logic [7:0] ip_ttl;
	} aem_hdr_t;
	typedef enum logic [2:0] {AEM_ST_IDLE = 3'b001, AEM_ST_ADDR = 3'b010, AEM_ST_DATA = 3'b100}
		aem_bus_st_t;
endpackage

// [logic/aem_matcher.sv]
// Access control entry matcher for ARP/RARP and IPv4 header fields, with an AHB-Lite register slave.
`timescale 1ns/1ps
`include "aem_params.svh"
// Operation
// R1: Sender-MAC check 1 needs ARP sender hw address equal source MAC; 0 needs differ.
// R2: Target-MAC check 1 needs RARP target hw address equal source MAC; 0 needs differ.
// R3: Length check 1 needs hardware length 6 and protocol length 4.
// R4: Hardware-space check 1 needs hardware space code equal to Ethernet, 1.
// R5: Protocol-space check 1 needs protocol space equal to IP, 0x800.
// R6: Setting 0 of length and space checks matches when the comparison fails.
// R7: Every three-way ARP/RARP check has an any setting that never blocks.
// R8: Sender address network mode compares only bits enabled by the mask.
// R9: Target address filter supports any, host exact match and network masked match.
// R10: IPv4 protocol and TTL checks apply only to entries of IPv4 frame type.
// R11: Protocol filter supports any, specific, ICMP, UDP and TCP selections.
// R12: Specific protocol mode matches only frames whose protocol equals the 8-bit value.
// R13: TTL zero mode blocks IPv4 frames whose TTL is above zero.
// R14: TTL non-zero mode allows frames with TTL above zero; any ignores TTL.
// R15: Opcode filter tells ARP from RARP; request/reply filter separate; both allow any.
// R16: Hit only when every enabled check of the frame type passes together.
module aem_matcher (
	input wire logic hclk, // Bus and matcher clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [11:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	output logic [31:0] hrdata, // Read data.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Always OKAY.
	input wire logic hdr_valid, // One-cycle strobe with a decoded header.
	input wire aem_pkg::aem_hdr_t hdr, // Decoded header fields.
	output logic res_valid, // One-cycle strobe, result of a header.
	output logic res_hit // Entry hit for that header.
);
	import aem_pkg::*;

	logic [31:0] ctrl_reg, arp_reg, spa_reg, spm_reg, tpa_reg, tpm_reg, ip_reg;
	logic [31:0] hits_reg;
	logic [11:0] wa_reg;
	logic wr_reg;
	aem_bus_st_t st_reg;
	logic [31:0] rd_next;
	logic hit_next;

	// Control: bit 1:0 entry frame type.  ARP word: 1:0 sender MAC, 3:2 target MAC,
	// 5:4 length, 7:6 hw space, 9:8 pro space, 11:10 opcode kind, 13:12 req/reply,
	// 15:14 sender addr mode, 17:16 target addr mode.  IP word: 7:0 value, 10:8 proto, 13:12 TTL.
	aem_ftype_t ent_type;
	aem_tri_t c_shw, c_tmac, c_len, c_hw, c_pro, c_ttl;
	aem_opk_t c_opk;
	aem_rr_t c_rr;
	aem_adr_t c_spa, c_tpa;
	aem_proto_t c_proto;
	assign ent_type = aem_ftype_t'(ctrl_reg[1:0]);
	assign c_shw = aem_tri_t'(arp_reg[1:0]);
	assign c_tmac = aem_tri_t'(arp_reg[3:2]);
	assign c_len = aem_tri_t'(arp_reg[5:4]);
	assign c_hw = aem_tri_t'(arp_reg[7:6]);
	assign c_pro = aem_tri_t'(arp_reg[9:8]);
	assign c_opk = aem_opk_t'(arp_reg[11:10]);
	assign c_rr = aem_rr_t'(arp_reg[13:12]);
	assign c_spa = aem_adr_t'(arp_reg[15:14]);
	assign c_tpa = aem_adr_t'(arp_reg[17:16]);
	assign c_proto = aem_proto_t'(ip_reg[10:8]);
	assign c_ttl = aem_tri_t'(ip_reg[13:12]);

	// A three-way check passes on any, on 1 when the comparison holds, on 0 when it fails.
	function automatic logic tri_ok(input aem_tri_t s, input logic eq);
		case (s)
			AEM_TRI_ANY: tri_ok = 1'b1; // see R7
			AEM_TRI_ONE: tri_ok = eq;
			AEM_TRI_ZERO: tri_ok = !eq; // see R6
			default: tri_ok = 1'b1;
		endcase
	endfunction

	function automatic logic adr_ok(input aem_adr_t m, input logic [31:0] a,
		input logic [31:0] cfg, input logic [31:0] msk);
		case (m)
			AEM_ADR_HOST: adr_ok = (a == cfg);
			AEM_ADR_NET: adr_ok = ((a & msk) == (cfg & msk)); // see R8
			default: adr_ok = 1'b1;
		endcase
	endfunction

	logic is_arp_op, is_rarp_op, is_req, is_rep;
	logic ok_opk, ok_rr, ok_arp, ok_proto, ok_ttl, ok_ip;
	assign is_arp_op = (hdr.opcode == `AEM_OP_ARP_REQ) || (hdr.opcode == `AEM_OP_ARP_REP);
	assign is_rarp_op = (hdr.opcode == `AEM_OP_RARP_REQ) || (hdr.opcode == `AEM_OP_RARP_REP);
	assign is_req = (hdr.opcode == `AEM_OP_ARP_REQ) || (hdr.opcode == `AEM_OP_RARP_REQ);
	assign is_rep = (hdr.opcode == `AEM_OP_ARP_REP) || (hdr.opcode == `AEM_OP_RARP_REP);

	always_comb begin
		case (c_opk) // see R15
			AEM_OPK_ARP: ok_opk = is_arp_op;
			AEM_OPK_RARP: ok_opk = is_rarp_op;
			AEM_OPK_OTHER: ok_opk = !is_arp_op && !is_rarp_op;
			default: ok_opk = 1'b1;
		endcase
		case (c_rr) // see R15
			AEM_RR_REQ: ok_rr = is_req;
			AEM_RR_REP: ok_rr = is_rep;
			default: ok_rr = 1'b1;
		endcase
	end

	// The MAC checks only constrain the opcode family they are defined for; other opcodes pass.
	assign ok_arp = ok_opk && ok_rr
		&& (!is_arp_op || tri_ok(c_shw, hdr.sender_hw == hdr.frame_source_hw_address)) // see R1
		&& (!is_rarp_op || tri_ok(c_tmac, hdr.target_hw == hdr.frame_source_hw_address)) // see R2
		&& tri_ok(c_len, (hdr.hw_len == `AEM_HLEN_ETH) && (hdr.pro_len == `AEM_PLEN_IP4)) // see R3
		&& tri_ok(c_hw, hdr.hw_space_code == `AEM_HW_ETH) // see R4
		&& tri_ok(c_pro, hdr.pro_space == `AEM_PRO_IP) // see R5
		&& adr_ok(c_spa, hdr.sender_protocol_address, spa_reg, spm_reg)
		&& adr_ok(c_tpa, hdr.target_protocol_address, tpa_reg, tpm_reg); // see R9

	always_comb begin
		case (c_proto) // see R11
			AEM_PR_SPEC: ok_proto = (hdr.ip_proto == ip_reg[7:0]); // see R12
			AEM_PR_ICMP: ok_proto = (hdr.ip_proto == `AEM_PROTO_ICMP);
			AEM_PR_UDP: ok_proto = (hdr.ip_proto == `AEM_PROTO_UDP);
			AEM_PR_TCP: ok_proto = (hdr.ip_proto == `AEM_PROTO_TCP);
			default: ok_proto = 1'b1;
		endcase
	end
	// Zero mode passes only TTL 0; non-zero passes only TTL above 0.
	assign ok_ttl = tri_ok(c_ttl, hdr.ip_ttl != 8'h00); // see R13 see R14
	assign ok_ip = ok_proto && ok_ttl;

	always_comb begin
		case (ent_type) // see R10
			AEM_FT_ARP: hit_next = (hdr.ftype == AEM_FT_ARP) && ok_arp; // see R16
			AEM_FT_IPV4: hit_next = (hdr.ftype == AEM_FT_IPV4) && ok_ip; // see R16
			default: hit_next = 1'b1;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_valid <= 1'b0;
			res_hit <= 1'b0;
		end else begin
			res_valid <= hdr_valid;
			res_hit <= hdr_valid && hit_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hits_reg <= 32'h0000_0000;
		end else if (hdr_valid && hit_next) begin
			hits_reg <= hits_reg + 32'h0000_0001;
		end
	end

	// Bus slave: zero wait states; a write's address phase is latched and acted on in the data phase; read data is registered from the live address phase.
	logic take;
	assign take = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= AEM_ST_IDLE;
			wa_reg <= 12'h000;
			wr_reg <= 1'b0;
		end else begin
			if (hready) begin
				st_reg <= take ? AEM_ST_DATA : AEM_ST_IDLE;
				wa_reg <= haddr;
				wr_reg <= take && hwrite;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= `AEM_CTRL_RST;
			arp_reg <= `AEM_ARP_RST;
			spa_reg <= 32'h0000_0000;
			spm_reg <= 32'h0000_0000;
			tpa_reg <= 32'h0000_0000;
			tpm_reg <= 32'h0000_0000;
			ip_reg <= `AEM_IP_RST;
		end else if (wr_reg && st_reg == AEM_ST_DATA) begin
			case (wa_reg)
				`AEM_OFF_CTRL: ctrl_reg <= {30'h0, hwdata[1:0]};
				`AEM_OFF_ARP: arp_reg <= {14'h0, hwdata[17:0]};
				`AEM_OFF_SPA: spa_reg <= hwdata;
				`AEM_OFF_SPM: spm_reg <= hwdata;
				`AEM_OFF_TPA: tpa_reg <= hwdata;
				`AEM_OFF_TPM: tpm_reg <= hwdata;
				`AEM_OFF_IP: ip_reg <= {18'h0, hwdata[13:12], 1'b0, hwdata[10:0]};
				default: ;
			endcase
		end
	end

	always_comb begin
		case (haddr)
			`AEM_OFF_CTRL: rd_next = ctrl_reg;
			`AEM_OFF_ARP: rd_next = arp_reg;
			`AEM_OFF_SPA: rd_next = spa_reg;
			`AEM_OFF_SPM: rd_next = spm_reg;
			`AEM_OFF_TPA: rd_next = tpa_reg;
			`AEM_OFF_TPM: rd_next = tpm_reg;
			`AEM_OFF_IP: rd_next = ip_reg;
			`AEM_OFF_STAT: rd_next = {30'h0, res_hit, res_valid};
			`AEM_OFF_HITS: rd_next = hits_reg;
			default: rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hrdata <= (take && !hwrite) ? rd_next : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	sequence s_hdr_arp_entry;
		hdr_valid && ent_type == AEM_FT_ARP;
	endsequence

	a_wrong_type_miss: assert property (@(posedge hclk) disable iff (!hresetn)
		s_hdr_arp_entry ##0 (hdr.ftype != AEM_FT_ARP) |=> !res_hit) // see R16
		else $error("ARP entry hit a non-ARP frame");
	a_shw_one_eq: assert property (@(posedge hclk) disable iff (!hresetn)
		s_hdr_arp_entry ##0 (is_arp_op && c_shw == AEM_TRI_ONE
		&& hdr.sender_hw != hdr.frame_source_hw_address) |=> !res_hit) // see R1
		else $error("sender MAC check 1 let a mismatch hit");
	a_tmac_zero_ne: assert property (@(posedge hclk) disable iff (!hresetn)
		s_hdr_arp_entry ##0 (is_rarp_op && c_tmac == AEM_TRI_ZERO
		&& hdr.target_hw == hdr.frame_source_hw_address) |=> !res_hit) // see R2
		else $error("target MAC check 0 let an equal address hit");
	a_len_check: assert property (@(posedge hclk) disable iff (!hresetn)
		s_hdr_arp_entry ##0 (c_len == AEM_TRI_ONE && hdr.hw_len != `AEM_HLEN_ETH) |=> !res_hit) // see R3
		else $error("length check let a wrong length hit");
	a_hw_space: assert property (@(posedge hclk) disable iff (!hresetn)
		s_hdr_arp_entry ##0 (c_hw == AEM_TRI_ZERO && hdr.hw_space_code == `AEM_HW_ETH) |=> !res_hit) // see R6
		else $error("hw space check 0 let Ethernet hit");
	a_pro_space: assert property (@(posedge hclk) disable iff (!hresetn)
		s_hdr_arp_entry ##0 (c_pro == AEM_TRI_ONE && hdr.pro_space != `AEM_PRO_IP) |=> !res_hit) // see R5
		else $error("protocol space check let a non-IP hit");
	a_tpa_host: assert property (@(posedge hclk) disable iff (!hresetn)
		s_hdr_arp_entry ##0 (c_tpa == AEM_ADR_HOST && hdr.target_protocol_address != tpa_reg)
		|=> !res_hit) // see R9
		else $error("target address host mode let a mismatch hit");
	a_ttl_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		hdr_valid && ent_type == AEM_FT_IPV4 && c_ttl == AEM_TRI_ZERO && hdr.ip_ttl != 8'h00
		|=> !res_hit) // see R13
		else $error("TTL zero mode let a live frame hit");
	a_proto_spec: assert property (@(posedge hclk) disable iff (!hresetn)
		hdr_valid && ent_type == AEM_FT_IPV4 && c_proto == AEM_PR_SPEC
		&& hdr.ip_proto != ip_reg[7:0] |=> !res_hit) // see R12
		else $error("specific protocol let another protocol hit");
	a_result_timing: assert property (@(posedge hclk) disable iff (!hresetn)
		res_hit |-> $past(hdr_valid) && res_valid) // see R16
		else $error("hit without a header one cycle before");
endmodule // aem_matcher

// [dv/aem_parser_model.sv]
// Stand-in for the ingress parser that hands decoded headers to the entry matcher.
`timescale 1ns/1ps
module aem_parser_model (
	input wire logic hclk, // Clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic send, // Present next_hdr at the coming edge.
	input wire aem_pkg::aem_hdr_t next_hdr, // Header to present.
	output logic hdr_valid, // One-cycle header strobe.
	output aem_pkg::aem_hdr_t hdr // Decoded header fields.
);
	import aem_pkg::*;
	// Between strobes the fields flip every cycle, so a matcher that reads stale fields is caught.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hdr_valid <= 1'b0;
			hdr <= '0;
		end else begin
			hdr_valid <= send;
			hdr <= send ? next_hdr : aem_hdr_t'(~hdr);
		end
	end
endmodule // aem_parser_model

// [dv/test_aem_matcher.sv]
// Self-checking bench for the entry matcher with a reference model of the match rules.
`timescale 1ns/1ps
`include "aem_params.svh"
module test_aem_matcher;
	import aem_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
	logic hdr_valid, res_valid, res_hit, send, pend, exp_hit;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd, r, seed, hit_cnt;
	logic [31:0] cfg [7];
	aem_hdr_t hdr, next_hdr;
	int fail_count, total_checks;
	assign hready = hreadyout;
	aem_matcher uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .hdr_valid(hdr_valid), .hdr(hdr),
		.res_valid(res_valid), .res_hit(res_hit));
	aem_parser_model far (.hclk(hclk), .hresetn(hresetn), .send(send), .next_hdr(next_hdr),
		.hdr_valid(hdr_valid), .hdr(hdr));
	always #50 hclk = ~hclk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic tri_ok(logic [1:0] s, logic c);
		return s == 2'h1 ? !c : s == 2'h2 ? c : 1'b1;
	endfunction
	function automatic logic adr_ok(logic [1:0] m, logic [31:0] v, logic [31:0] a, logic [31:0] k);
		return m == 2'h1 ? v == a : m == 2'h2 ? ((v ^ a) & k) == 32'h0 : 1'b1;
	endfunction
	function automatic logic model(aem_hdr_t h);
		logic [31:0] a, p;
		logic arp_op, rarp_op, ok;
		a = cfg[1];
		p = cfg[6];
		arp_op = h.opcode inside {16'h1, 16'h2};
		rarp_op = h.opcode inside {16'h3, 16'h4};
		if (cfg[0][1:0] == 2'h2) begin
			ok = h.ftype == AEM_FT_IPV4;
			ok &= p[10:8] == 3'h1 ? h.ip_proto == p[7:0] : 1'b1;
			ok &= p[10:8] == 3'h2 ? h.ip_proto == 8'h01 : 1'b1;
			ok &= p[10:8] == 3'h3 ? h.ip_proto == 8'h11 : 1'b1;
			ok &= p[10:8] == 3'h4 ? h.ip_proto == 8'h06 : 1'b1;
			return ok && tri_ok(p[13:12], h.ip_ttl != 8'h00);
		end
		if (cfg[0][1:0] != 2'h1)
			return 1'b1;
		ok = h.ftype == AEM_FT_ARP;
		ok &= !arp_op || tri_ok(a[1:0], h.sender_hw == h.frame_source_hw_address);
		ok &= !rarp_op || tri_ok(a[3:2], h.target_hw == h.frame_source_hw_address);
		ok &= tri_ok(a[5:4], h.hw_len == 8'h06 && h.pro_len == 8'h04);
		ok &= tri_ok(a[7:6], h.hw_space_code == 16'h0001);
		ok &= tri_ok(a[9:8], h.pro_space == 16'h0800);
		ok &= a[11:10] == 2'h1 ? arp_op : a[11:10] == 2'h2 ? rarp_op : 1'b1;
		ok &= a[11:10] == 2'h3 ? !(arp_op || rarp_op) : 1'b1;
		ok &= a[13:12] == 2'h1 ? h.opcode inside {16'h1, 16'h3} : 1'b1;
		ok &= a[13:12] == 2'h2 ? h.opcode inside {16'h2, 16'h4} : 1'b1;
		ok &= adr_ok(a[15:14], h.sender_protocol_address, cfg[2], cfg[3]);
		return ok && adr_ok(a[17:16], h.target_protocol_address, cfg[4], cfg[5]);
	endfunction
	// Fields are steered near the configured values so that both outcomes of each check occur.
	function automatic aem_hdr_t mkhdr(logic [31:0] x);
		aem_hdr_t h;
		logic [47:0] src;
		src = {16'h0a0b, rnd()};
		// A quarter of the frames carry a random type, so an entry also meets foreign frames.
		h.ftype = aem_ftype_t'(x[31] | x[30] ? cfg[0][1:0] : 2'(rnd() % 32'h3));
		h.frame_source_hw_address = src;
		h.sender_hw = x[0] ? src : src ^ 48'h1;
		h.target_hw = x[1] ? src : src ^ 48'h100;
		h.hw_len = x[2] ? 8'h06 : 8'h08;
		h.pro_len = x[3] ? 8'h04 : 8'h10;
		h.hw_space_code = x[4] ? 16'h0001 : 16'h0006;
		h.pro_space = x[5] ? 16'h0800 : 16'h86dd;
		h.opcode = {13'h0, x[8:6]};
		h.sender_protocol_address = cfg[2] ^ (x[9] ? 32'h0 : {24'h0, x[17:10]});
		h.target_protocol_address = cfg[4] ^ (x[18] ? 32'h0 : {16'h0, x[26:19], 8'h0});
		h.ip_proto = x[27] ? (x[28] ? cfg[6][7:0] : 8'h11) : (x[28] ? 8'h06 : 8'h01);
		h.ip_ttl = x[29] ? 8'h00 : {x[15:9], 1'b1};
		return h;
	endfunction
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		check("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic configure(input int n);
		logic [31:0] a;
		// The single-field passes never pick any, so every field is seen in force.
		a = n / 3 < 9 ? (32'h1 + rnd() % 32'h2) << (2 * (n / 3)) : rnd() & 32'h0003_ffff;
		if (a[13:12] == 2'h3) a[13:12] = 2'h0;
		if (a[15:14] == 2'h3) a[15:14] = 2'h0;
		if (a[17:16] == 2'h3) a[17:16] = 2'h0;
		cfg[0] = 32'(n % 3);
		cfg[1] = a;
		cfg[2] = rnd();
		cfg[3] = n % 2 ? 32'hffff_ff00 : 32'hffff_ff0f;
		cfg[4] = rnd();
		cfg[5] = n % 2 ? 32'hffff_ffff : 32'hffff_0000;
		cfg[6] = rnd() & 32'h0000_37ff;
		if (cfg[6][13:12] == 2'h3) cfg[6][13:12] = 2'h0;
		for (int i = 0; i < 7; i++) bus(1'b1, 12'(4 * i), cfg[i]);
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, 12'(4 * i), 32'h0);
			check("config readback", cfg[i], rd);
		end
	endtask
	task automatic complete_run();
		if (fail_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge hclk) begin
		if (hresetn === 1'b1) begin
			check("res_valid", {31'h0, pend}, {31'h0, res_valid});
			if (pend) check("res_hit", {31'h0, exp_hit}, {31'h0, res_hit});
			pend = hdr_valid;
			exp_hit = hdr_valid && model(hdr);
			hit_cnt = hit_cnt + {31'h0, exp_hit};
		end
	end
	initial begin
		#2000000;
		fail_count++;
		complete_run();
	end
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		{hsel, hwrite, send, pend, exp_hit, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		next_hdr = '0;
		seed = 32'h13;
		hit_cnt = 32'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 9; i++) begin
			bus(1'b0, 12'(4 * i), 32'h0);
			check("reset value", 32'h0, rd);
		end
		bus(1'b1, 12'h044, 32'hffff_ffff);
		bus(1'b0, 12'h044, 32'h0);
		check("unmapped read", 32'h0, rd);
		for (int n = 0; n < 72; n++) begin
			configure(n);
			repeat (20) begin
				r = rnd();
				send <= 1'b1;
				next_hdr <= mkhdr(r);
				@(posedge hclk);
				if (r[30]) begin
					send <= 1'b0;
					repeat (1 + r[25:24]) @(posedge hclk);
				end
			end
			send <= 1'b0;
			repeat (4) @(posedge hclk);
			bus(1'b0, `AEM_OFF_HITS, 32'h0);
			check("hit counter", hit_cnt, rd);
		end
		bus(1'b1, `AEM_OFF_HITS, 32'h0);
		bus(1'b0, `AEM_OFF_HITS, 32'h0);
		check("hit counter after write", hit_cnt, rd);
		complete_run();
	end
endmodule // test_aem_matcher
